//--- core/cmr_defs.svh
// Constants for the address map and core control block
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH
`define CMR_OFS_PC 8'h00
`define CMR_OFS_PSW 8'h04
`define CMR_OFS_SP 8'h08
`define CMR_OFS_CFG 8'h0C
`define CMR_OFS_STAT 8'h10
`define CMR_PSW_RST 8'h06
`define CMR_BIT_IE 7
`define CMR_BIT_Z 6
`define CMR_BIT_AC 4
`define CMR_BIT_ISPH 2
`define CMR_BIT_ISPL 1
`define CMR_BIT_CY 0
`define CMR_CFG_MIR2K 0
`define CMR_CFG_RAM256 1
`define CMR_VEC_BRK 20'h0007E
`define CMR_VEC_BRK_SEL 4'hF
`define CMR_VEC_LAST_SEL 4'hB
`define CMR_VECT_END 20'h0007F
`define CMR_TABLE_CALL_BASE 20'h00080
`define CMR_TABLE_CALL_END 20'h000BF
`define CMR_OPT_BASE 20'h000C0
`define CMR_OPT_END 20'h000C3
`define CMR_SID0_BASE 20'h000C4
`define CMR_SID0_END 20'h000CD
`define CMR_SID1_BASE 20'h010C4
`define CMR_SID1_END 20'h010CD
`define CMR_FL1K_END 20'h003FF
`define CMR_FL2K_END 20'h007FF
`define CMR_MIR_BASE 20'hF8000
`define CMR_MIR1K_END 20'hF83FF
`define CMR_MIR2K_END 20'hF87FF
`define CMR_RAM128_BASE 20'hFFE60
`define CMR_RAM256_BASE 20'hFFDE0
`define CMR_RAM_END 20'hFFEDF
`define CMR_GPR_BASE 20'hFFEF8
`define CMR_GPR_END 20'hFFEFF
`define CMR_SFR_BASE 20'hFFF00
`define CMR_SFR_END 20'hFFFFF
`define CMR_XSFR_BASE 20'hF0000
`define CMR_XSFR_END 20'hF07FF
`define CMR_RESP_OK 2'h0
`define CMR_RESP_ERR 2'h2
`endif

//--- core/cmr_pkg.sv
// Types shared by the address map and core control block
package cmr_pkg;
	typedef enum logic [3:0] {
		REG_VECTOR, REG_TABLE_CALL, REG_OPTION, REG_SECID, REG_FLASH,
		REG_MIRROR, REG_RAM, REG_GPR, REG_SFR, REG_XSFR, REG_RESERVED
	} cmr_region_type;
	typedef enum logic [1:0] {
		ALU_ARITH, ALU_ROTATE, ALU_BITOP, ALU_LOGIC
	} cmr_alu_type;
	typedef enum logic {ST_BOOT, ST_RUN} cmr_state_type;
endpackage

//--- core/cmr_core_ctrl.sv
// Address decode and control registers of the core
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "cmr_defs.svh"
module cmr_core_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Vector and table lookup
	input wire logic [3:0] vecSel,
	input wire logic [4:0] tableIdx,
	input wire logic vecLoad,
	input wire logic [15:0] vecData,
	output logic bootVecReq,
	output logic [19:0] vecAddr,
	output logic [19:0] tableAddr,
	// Program flow
	input wire logic fetchStep,
	input wire logic [2:0] fetchLen,
	input wire logic branchLoad,
	input wire logic [19:0] branchTarget,
	output logic [19:0] next_instruction_pointer,
	// Address decode
	input wire logic [19:0] fetchAddr,
	input wire logic [19:0] dataAddr,
	input wire logic dataWrite,
	output logic [3:0] dataRegion,
	output logic [19:0] dataPhysAddr,
	output logic dataFault,
	output logic fetchFault,
	output logic extraOpByte,
	output logic [2:0] gprIndex,
	// Status word and interrupts
	input wire logic irqReq,
	input wire logic irqMasked,
	input wire logic [1:0] irqPrio,
	input wire logic irqAck,
	input wire logic irqDisableOp,
	input wire logic irqEnableOp,
	input wire logic popStatus,
	input wire logic [7:0] popData,
	input wire logic aluUpd,
	input wire logic [1:0] aluKind,
	input wire logic [7:0] aluResult,
	input wire logic aluNibbleCarry,
	input wire logic aluCarry,
	output logic [7:0] status_flags_word,
	output logic irqAccept,
	// Stack
	input wire logic stackPush,
	input wire logic stackPop,
	input wire logic [1:0] stackBytes,
	output logic [15:0] stack_top_pointer,
	output logic stackFault
);
	cmr_pkg::cmr_state_type state;
	logic [7:0] cfg;
	logic [7:0] awAddr;
	logic awHeld;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic wHeld;

	function automatic cmr_pkg::cmr_region_type decode(
		input logic [19:0] a, input logic mir2k, input logic ram256);
		logic [19:0] ramBase;
		ramBase = ram256 ? `CMR_RAM256_BASE : `CMR_RAM128_BASE;
		decode = cmr_pkg::REG_RESERVED;
		if (a <= `CMR_VECT_END)
			decode = cmr_pkg::REG_VECTOR;
		else if (a <= `CMR_TABLE_CALL_END)
			decode = cmr_pkg::REG_TABLE_CALL;
		else if (a <= `CMR_OPT_END)
			decode = cmr_pkg::REG_OPTION;
		else if (a <= `CMR_SID0_END)
			decode = cmr_pkg::REG_SECID;
		else if (a >= `CMR_SID1_BASE && a <= `CMR_SID1_END)
			decode = cmr_pkg::REG_SECID;
		else if (a <= `CMR_FL2K_END)
			decode = cmr_pkg::REG_FLASH;
		else if (a >= `CMR_XSFR_BASE && a <= `CMR_XSFR_END)
			decode = cmr_pkg::REG_XSFR;
		else if (a >= `CMR_MIR_BASE &&
			a <= (mir2k ? `CMR_MIR2K_END : `CMR_MIR1K_END))
			decode = cmr_pkg::REG_MIRROR;
		else if (a >= ramBase && a <= `CMR_RAM_END)
			decode = cmr_pkg::REG_RAM;
		else if (a >= `CMR_GPR_BASE && a <= `CMR_GPR_END)
			decode = cmr_pkg::REG_GPR;
		else if (a >= `CMR_SFR_BASE)
			decode = cmr_pkg::REG_SFR;
	endfunction

	// Register bus decode
	wire wrFire = awHeld && wHeld && !s_axi_bvalid;
	wire wrPc = wrFire && awAddr == `CMR_OFS_PC;
	wire wrPsw = wrFire && awAddr == `CMR_OFS_PSW;
	wire wrSp = wrFire && awAddr == `CMR_OFS_SP;
	wire wrCfg = wrFire && awAddr == `CMR_OFS_CFG;
	wire wrOk = wrPc || wrPsw || wrSp || wrCfg;
	wire arFire = s_axi_arvalid && s_axi_arready;
	wire [31:0] wMask = {{8{wStrb[3]}}, {8{wStrb[2]}},
		{8{wStrb[1]}}, {8{wStrb[0]}}};
	wire [31:0] wrPcVal = ({12'h000, next_instruction_pointer} & ~wMask)
		| (wData & wMask);
	wire [15:0] wrSpVal = (stack_top_pointer & ~wMask[15:0])
		| (wData[15:0] & wMask[15:0]);
	wire [7:0] wrPswVal = (status_flags_word & ~wMask[7:0])
		| (wData[7:0] & wMask[7:0]);

	// Address decode of fetch and data
	wire mir2k = cfg[`CMR_CFG_MIR2K];
	wire ram256 = cfg[`CMR_CFG_RAM256];
	cmr_pkg::cmr_region_type fetchReg;
	cmr_pkg::cmr_region_type dataReg;
	assign fetchReg = decode(fetchAddr, mir2k, ram256);
	assign dataReg = decode(dataAddr, mir2k, ram256);
	wire fetchBad = fetchReg == cmr_pkg::REG_MIRROR
		|| fetchReg == cmr_pkg::REG_GPR
		|| fetchReg == cmr_pkg::REG_RESERVED;
	wire dataBad = dataReg == cmr_pkg::REG_RESERVED
		|| (dataWrite && dataReg == cmr_pkg::REG_MIRROR);
	wire [19:0] physAddr = dataReg == cmr_pkg::REG_MIRROR
		? (dataAddr - `CMR_MIR_BASE) : dataAddr;
	wire [3:0] statWord = {state == cmr_pkg::ST_RUN, stackFault,
		fetchFault, dataFault};

	// Vector and table-call addresses
	wire [19:0] vecSelAddr = (vecSel == `CMR_VEC_BRK_SEL)
		? `CMR_VEC_BRK
		: (vecSel == 4'h0 || vecSel > `CMR_VEC_LAST_SEL) ? 20'h00000
		: {15'h0000, vecSel, 1'b0} + 20'h00002;
	wire [19:0] tableSelAddr = `CMR_TABLE_CALL_BASE
		+ {14'h0000, tableIdx, 1'b0};

	// Program counter
	logic [19:0] next_pc;
	always_comb begin
		next_pc = next_instruction_pointer;
		if (wrPc)
			next_pc = wrPcVal[19:0];
		if (fetchStep)
			next_pc = next_instruction_pointer
				+ {17'h00000, fetchLen};
		if (branchLoad)
			next_pc = branchTarget;
		if (vecLoad)
			next_pc = {4'h0, vecData};
	end

	// Status word
	logic [7:0] next_psw;
	always_comb begin
		next_psw = status_flags_word;
		if (wrPsw)
			next_psw = wrPswVal;
		if (popStatus)
			next_psw = popData;
		if (aluUpd) begin
			unique case (cmr_pkg::cmr_alu_type'(aluKind))
			cmr_pkg::ALU_ARITH: begin
				next_psw[`CMR_BIT_Z] = aluResult == 8'h00;
				next_psw[`CMR_BIT_AC] = aluNibbleCarry;
				next_psw[`CMR_BIT_CY] = aluCarry;
			end
			cmr_pkg::ALU_ROTATE,
			cmr_pkg::ALU_BITOP: begin
				next_psw[`CMR_BIT_CY] = aluCarry;
			end
			cmr_pkg::ALU_LOGIC: begin
				next_psw[`CMR_BIT_Z] = aluResult == 8'h00;
			end
			endcase
		end
		if (irqAck) begin
			next_psw[`CMR_BIT_ISPH:`CMR_BIT_ISPL] = irqPrio;
		end
		if (irqAck || irqDisableOp)
			next_psw[`CMR_BIT_IE] = 1'b0;
		else if (irqEnableOp)
			next_psw[`CMR_BIT_IE] = 1'b1;
	end
	// A request is refused when its level value exceeds the in-service one
	wire irqGate = status_flags_word[`CMR_BIT_IE] && irqReq && !irqMasked
		&& irqPrio <= status_flags_word[`CMR_BIT_ISPH:`CMR_BIT_ISPL];

	// Stack pointer; push and pop in one cycle cancel
	logic [15:0] next_sp;
	always_comb begin
		next_sp = stack_top_pointer;
		if (wrSp)
			next_sp = wrSpVal;
		if (stackPush && !stackPop)
			next_sp = stack_top_pointer
				- {14'h0000, stackBytes};
		else if (stackPop && !stackPush)
			next_sp = stack_top_pointer
				+ {14'h0000, stackBytes};
	end
	wire [19:0] spAbs = {4'hF, stack_top_pointer};
	wire spBad = decode(spAbs, mir2k, ram256) != cmr_pkg::REG_RAM;

	// Read data select
	wire rdPc = s_axi_araddr == `CMR_OFS_PC;
	wire rdPsw = s_axi_araddr == `CMR_OFS_PSW;
	wire rdSp = s_axi_araddr == `CMR_OFS_SP;
	wire rdCfg = s_axi_araddr == `CMR_OFS_CFG;
	wire rdStat = s_axi_araddr == `CMR_OFS_STAT;
	wire rdOk = rdPc || rdPsw || rdSp || rdCfg || rdStat;
	wire [31:0] rdVal = rdPc ? {12'h000, next_instruction_pointer}
		: rdPsw ? {24'h000000, status_flags_word}
		: rdSp ? {16'h0000, stack_top_pointer}
		: rdCfg ? {24'h000000, cfg}
		: rdStat ? {20'h00000, fetchReg, statWord, dataReg}
		: 32'h00000000;

	// Bus channels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
			wHeld <= 1'b0;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CMR_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end else if (wrFire)
				awHeld <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end else if (wrFire)
				wHeld <= 1'b0;
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? `CMR_RESP_OK : `CMR_RESP_ERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
			s_axi_arready <= !s_axi_rvalid && !arFire;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CMR_RESP_OK;
		end else if (arFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdVal;
			s_axi_rresp <= rdOk ? `CMR_RESP_OK : `CMR_RESP_ERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Core control state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= cmr_pkg::ST_BOOT;
			bootVecReq <= 1'b1;
			next_instruction_pointer <= 20'h00000;
			status_flags_word <= `CMR_PSW_RST;
			stack_top_pointer <= 16'h0000;
			cfg <= 8'h00;
			irqAccept <= 1'b0;
		end else begin
			if (state == cmr_pkg::ST_BOOT && vecLoad) begin
				state <= cmr_pkg::ST_RUN;
				bootVecReq <= 1'b0;
			end
			next_instruction_pointer <= next_pc;
			status_flags_word <= next_psw;
			stack_top_pointer <= next_sp;
			if (wrCfg && wStrb[0])
				cfg <= {6'h00, wData[1:0]};
			irqAccept <= irqGate;
		end
	end

	// Decode results, registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vecAddr <= 20'h00000;
			tableAddr <= `CMR_TABLE_CALL_BASE;
			dataRegion <= 4'h0;
			dataPhysAddr <= 20'h00000;
			dataFault <= 1'b0;
			fetchFault <= 1'b0;
			extraOpByte <= 1'b0;
			gprIndex <= 3'h0;
			stackFault <= 1'b0;
		end else begin
			vecAddr <= bootVecReq ? 20'h00000 : vecSelAddr;
			tableAddr <= tableSelAddr;
			dataRegion <= dataReg;
			dataPhysAddr <= physAddr;
			dataFault <= dataBad;
			fetchFault <= fetchBad;
			extraOpByte <= dataReg == cmr_pkg::REG_XSFR;
			gprIndex <= dataAddr[2:0];
			stackFault <= (stackPush || stackPop) && spBad;
		end
	end

	AST_PSW_RESET: assert property (@(posedge clk)
		$rose(rst_n) |-> status_flags_word == 8'h06)
		else $error("status word not 06H after reset");
	AST_BOOT_LOAD: assert property (
		@(posedge clk) disable iff (!rst_n)
		bootVecReq && vecLoad |=> next_instruction_pointer ==
		{4'h0, $past(vecData)} && !bootVecReq)
		else $error("reset vector not loaded");
	AST_PC_STEP: assert property (
		@(posedge clk) disable iff (!rst_n)
		fetchStep && !branchLoad && !vecLoad |=>
		next_instruction_pointer == $past(next_instruction_pointer)
		+ {17'h00000, $past(fetchLen)})
		else $error("counter did not advance by length");
	AST_IE_CLEAR: assert property (
		@(posedge clk) disable iff (!rst_n)
		irqAck || irqDisableOp |=> !status_flags_word[`CMR_BIT_IE])
		else $error("allow flag not cleared");
	AST_IE_BLOCK: assert property (
		@(posedge clk) disable iff (!rst_n)
		!status_flags_word[`CMR_BIT_IE] |=> !irqAccept)
		else $error("request accepted while disallowed");
	AST_PRIO_REFUSE: assert property (
		@(posedge clk) disable iff (!rst_n)
		irqPrio > status_flags_word[`CMR_BIT_ISPH:`CMR_BIT_ISPL]
		|=> !irqAccept)
		else $error("lower priority request accepted");
	AST_ZERO_FLAG: assert property (
		@(posedge clk) disable iff (!rst_n)
		aluUpd && aluKind == 2'h0 && !popStatus |=>
		status_flags_word[`CMR_BIT_Z] == ($past(aluResult) == 8'h00)
		&& status_flags_word[`CMR_BIT_AC] == $past(aluNibbleCarry))
		else $error("zero or nibble carry wrong");
	AST_CARRY: assert property (
		@(posedge clk) disable iff (!rst_n)
		aluUpd && aluKind != 2'h3 && !popStatus |=>
		status_flags_word[`CMR_BIT_CY] == $past(aluCarry))
		else $error("carry flag wrong");
	AST_SP_PUSH: assert property (
		@(posedge clk) disable iff (!rst_n)
		stackPush && !stackPop |=> stack_top_pointer ==
		$past(stack_top_pointer) - {14'h0000, $past(stackBytes)})
		else $error("stack pointer not pre-decremented");
	AST_MIRROR_FETCH: assert property (
		@(posedge clk) disable iff (!rst_n)
		fetchAddr >= `CMR_MIR_BASE && fetchAddr <= `CMR_MIR1K_END
		|=> fetchFault)
		else $error("fetch from mirror not flagged");
	AST_POP_PSW: assert property (
		@(posedge clk) disable iff (!rst_n)
		popStatus && !aluUpd && !irqAck && !irqDisableOp
		&& !irqEnableOp |=> status_flags_word == $past(popData))
		else $error("status word not restored");
	AST_BRESP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule

//--- bench/cmr_core_ctrl_tb_top.sv
// Self-checking bench for the address map and core control block
`timescale 1ns/1ps
`include "cmr_defs.svh"
module cmr_core_ctrl_tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF, vecSel = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	// Pulses: 0 vec, 1 step, 2 branch, 3 ack, 4 dis, 5 en, 6 pop, 7 alu
	// 8 push, 9 pop of stack
	logic [9:0] pls = 10'h000;
	logic [4:0] tableIdx = 5'h00;
	logic [15:0] vecData = 16'h0000;
	logic [2:0] fetchLen = 3'h0;
	logic [19:0] branchTarget = 20'h0, fetchAddr = 20'h0, dataAddr = 20'h0;
	logic dataWrite = 1'h0, irqReq = 1'h0, irqMasked = 1'h0;
	logic aluNibbleCarry = 1'h0, aluCarry = 1'h0;
	logic [1:0] irqPrio = 2'h0, aluKind = 2'h0, stackBytes = 2'h0;
	logic [7:0] popData = 8'h00, aluResult = 8'h00, status_flags_word;
	logic bootVecReq, dataFault, fetchFault, extraOpByte, irqAccept;
	logic stackFault, sawFault;
	logic [19:0] vecAddr, tableAddr, next_instruction_pointer, dataPhysAddr;
	logic [3:0] dataRegion;
	logic [2:0] gprIndex;
	logic [15:0] stack_top_pointer;
	int failures = 0, totalChecks = 0;
	// Region codes follow the package enum order
	localparam logic [19:0] DA [16] = '{20'h0007F, 20'h00080, 20'h000BF,
		20'h000C0, 20'h000C3, 20'h000C4, 20'h010CD, 20'h00100, 20'hF87FF,
		20'hFFDE0, 20'hFFEDF, 20'hFFEF8, 20'hFFF00, 20'hFFFFF, 20'hF07FF,
		20'hF0800};
	localparam logic [3:0] DR [16] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3,
		4'h3, 4'h4, 4'h5, 4'h6, 4'h6, 4'h7, 4'h8, 4'h8, 4'h9, 4'hA};

	cmr_core_ctrl dut_u (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .vecSel, .tableIdx,
		.vecLoad(pls[0]), .vecData, .bootVecReq, .vecAddr, .tableAddr,
		.fetchStep(pls[1]), .fetchLen, .branchLoad(pls[2]), .branchTarget,
		.next_instruction_pointer, .fetchAddr, .dataAddr, .dataWrite,
		.dataRegion, .dataPhysAddr, .dataFault, .fetchFault, .extraOpByte,
		.gprIndex, .irqReq, .irqMasked, .irqPrio, .irqAck(pls[3]),
		.irqDisableOp(pls[4]), .irqEnableOp(pls[5]), .popStatus(pls[6]),
		.popData, .aluUpd(pls[7]), .aluKind, .aluResult, .aluNibbleCarry,
		.aluCarry, .status_flags_word, .irqAccept, .stackPush(pls[8]),
		.stackPop(pls[9]), .stackBytes, .stack_top_pointer, .stackFault
	);

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic complete_run();
		if (failures == 0 && totalChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Registered outputs lag their cause, so give them three edges
	// Read at the edge: the value seen is what the previous edge launched,
	// so a one-cycle fault flag is caught on the way
	task automatic settle();
		repeat (3) begin
			@(posedge clk);
			sawFault |= stackFault;
		end
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		pls[k] <= 1'h1;
		@(posedge clk);
		pls <= 10'h000;
		settle();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'h1;
		w = 1'h1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && s_axi_awready === 1'h1) begin
				aw = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready === 1'h1) begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (s_axi_bvalid !== 1'h1) @(posedge clk);
		s_axi_bready <= 1'h0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		@(posedge clk);
		while (s_axi_arready !== 1'h1) @(posedge clk);
		s_axi_arvalid <= 1'h0;
		@(posedge clk);
		while (s_axi_rvalid !== 1'h1) @(posedge clk);
		s_axi_rready <= 1'h0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
	endtask

	// Whole sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial begin
		sawFault = 1'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		settle();
		chk("bootVecReq", 32'h1, 32'(bootVecReq));
		chk("status", 32'h06, 32'(status_flags_word));
		axr(`CMR_OFS_PSW, 32'h06, `CMR_RESP_OK);
		axr(8'h14, 32'h0, `CMR_RESP_ERR);
		axw(8'h14, 32'h5, `CMR_RESP_ERR);
		axw(`CMR_OFS_PC, 32'h12345, `CMR_RESP_OK);
		axr(`CMR_OFS_PC, 32'h12345, `CMR_RESP_OK);
		branchTarget <= 20'hF1234;
		pulse(2);
		chk("pc", 32'hF1234, 32'(next_instruction_pointer));
		fetchLen <= 3'h3;
		pulse(1);
		chk("pc", 32'hF1237, 32'(next_instruction_pointer));
		vecData <= 16'hABCD;
		pulse(0);
		chk("pc", 32'h0ABCD, 32'(next_instruction_pointer));
		chk("bootVecReq", 32'h0, 32'(bootVecReq));
		for (int i = 1; i <= 11; i++) begin
			vecSel <= 4'(i);
			settle();
			chk("vecAddr", 32'(2 * i + 2), 32'(vecAddr));
		end
		vecSel <= `CMR_VEC_BRK_SEL;
		tableIdx <= 5'h1F;
		settle();
		chk("vecAddr", 32'h7E, 32'(vecAddr));
		chk("tableAddr", 32'hBE, 32'(tableAddr));
		axw(`CMR_OFS_CFG, 32'h3, `CMR_RESP_OK);
		for (int i = 0; i < 16; i++) begin
			dataAddr <= DA[i];
			settle();
			chk("region", 32'(DR[i]), 32'(dataRegion));
		end
		dataAddr <= 20'hF8123;
		fetchAddr <= 20'hF8000;
		settle();
		chk("phys", 32'h123, 32'(dataPhysAddr));
		chk("fetchFault", 32'h1, 32'(fetchFault));
		chk("dataFault", 32'h0, 32'(dataFault));
		dataWrite <= 1'h1;
		fetchAddr <= 20'hFFE60;
		settle();
		chk("dataFault", 32'h1, 32'(dataFault));
		chk("fetchFault", 32'h0, 32'(fetchFault));
		axw(`CMR_OFS_CFG, 32'h0, `CMR_RESP_OK);
		dataWrite <= 1'h0;
		dataAddr <= 20'hF8400;
		fetchAddr <= 20'hFFEF8;
		settle();
		chk("region", 32'hA, 32'(dataRegion));
		chk("fetchFault", 32'h1, 32'(fetchFault));
		dataAddr <= 20'hFFDE0;
		settle();
		chk("region", 32'hA, 32'(dataRegion));
		dataAddr <= 20'hF0010;
		settle();
		chk("extraOpByte", 32'h1, 32'(extraOpByte));
		dataAddr <= 20'hFFEFD;
		settle();
		chk("gprIndex", 32'h5, 32'(gprIndex));
		chk("extraOpByte", 32'h0, 32'(extraOpByte));
		irqReq <= 1'h1;
		irqPrio <= 2'h2;
		pulse(5);
		chk("status", 32'h86, 32'(status_flags_word));
		chk("irqAccept", 32'h1, 32'(irqAccept));
		irqMasked <= 1'h1;
		settle();
		chk("irqAccept", 32'h0, 32'(irqAccept));
		irqMasked <= 1'h0;
		irqPrio <= 2'h1;
		pulse(3);
		chk("status", 32'h02, 32'(status_flags_word));
		pulse(5);
		irqPrio <= 2'h2;
		settle();
		chk("irqAccept", 32'h0, 32'(irqAccept));
		irqPrio <= 2'h1;
		settle();
		chk("irqAccept", 32'h1, 32'(irqAccept));
		pulse(4);
		chk("status", 32'h02, 32'(status_flags_word));
		chk("irqAccept", 32'h0, 32'(irqAccept));
		aluNibbleCarry <= 1'h1;
		aluCarry <= 1'h1;
		pulse(7);
		chk("status", 32'h53, 32'(status_flags_word));
		aluResult <= 8'h10;
		aluCarry <= 1'h0;
		aluNibbleCarry <= 1'h0;
		pulse(7);
		chk("status", 32'h02, 32'(status_flags_word));
		aluKind <= 2'h1;
		aluCarry <= 1'h1;
		aluNibbleCarry <= 1'h1;
		pulse(7);
		chk("status", 32'h03, 32'(status_flags_word));
		aluKind <= 2'h3;
		aluResult <= 8'h00;
		pulse(7);
		chk("status", 32'h43, 32'(status_flags_word));
		aluKind <= 2'h2;
		aluCarry <= 1'h0;
		pulse(7);
		chk("status", 32'h42, 32'(status_flags_word));
		popData <= 8'hD7;
		pulse(6);
		axr(`CMR_OFS_PSW, 32'hD7, `CMR_RESP_OK);
		axw(`CMR_OFS_SP, 32'hFE80, `CMR_RESP_OK);
		stackBytes <= 2'h2;
		sawFault = 1'h0;
		pulse(8);
		chk("sp", 32'hFE7E, 32'(stack_top_pointer));
		stackBytes <= 2'h1;
		pulse(9);
		chk("sp", 32'hFE7F, 32'(stack_top_pointer));
		chk("stackFault", 32'h0, 32'(sawFault));
		axw(`CMR_OFS_SP, 32'hFEF8, `CMR_RESP_OK);
		pulse(8);
		chk("stackFault", 32'h1, 32'(sawFault));
		// Fetch and data both in the general registers, running, fetch fault set
		axr(`CMR_OFS_STAT, 32'h7A7, `CMR_RESP_OK);
		complete_run();
	end
endmodule
